// ### hsw_top.sv
// Mutual supervision watchdog pair: internal CPU and external host
`timescale 1ns/1ps

// Notes on behaviour
// - Two independent watchdogs, one for the internal CPU, one for the host.
// - Every rising host kick edge reloads the host watchdog to full interval.
// - Internal watchdog expiry drives the expiry output low.
// - Expiry output high from power-up; internal watchdog runs from start-up.
// - Internal expiry forces a whole-device reset, dropping all connections.
// - Host expiry raises a diagnostic alarm and marks input data bad.
// - Host checking starts only after the configuration-done event.
// - Host interval selectable from 1 ms to 512 ms.
// - Interval zero disables host supervision entirely.
// - A new interval takes effect only after the next arst_n_in release, not after a device reset.
module hsw_top
    import hsw_pkg::*;
#(
    parameter int unsigned TICK_DIVIDE = TICK_CYCLES,
    parameter int unsigned CPU_LIMIT   = CPU_TIMEOUT_MS
)
(
    input  wire logic                  mclk_in,
    input  wire logic                  arst_n_in,
    input  wire logic                  host_kick_in,
    input  wire logic                  cpu_kick_in,
    input  wire logic                  app_config_done_event_in,
    input  wire logic [INTERVAL_W-1:0] boot_interval_in,
    output logic                       wdt_expired_n_out,
    output logic                       device_reset_n_out,
    output logic                       host_active_out,
    output hsw_diag_s                  diag_out
);
    if (CPU_LIMIT < INTERVAL_MIN_MS || CPU_LIMIT > INTERVAL_MAX_MS)
    begin : g_cpu_limit_check
        $error("CPU_LIMIT outside 1..512 ms");
    end

    localparam logic [INTERVAL_W-1:0] CPU_LIMIT_W = INTERVAL_W'(CPU_LIMIT);

    logic tick;
    logic host_kick_meta;
    logic host_kick_sync;
    logic host_kick_prev;
    logic cfg_meta;
    logic cfg_sync;
    logic latched;
    logic [INTERVAL_W-1:0] interval;
    logic [INTERVAL_W-1:0] next_interval;
    logic next_latched;
    logic kick_rise;
    logic cpu_expire;
    logic host_expire;
    logic host_run;
    hsw_state_e state;
    hsw_state_e next_state;
    hsw_diag_s  next_diag;
    logic       next_wdt_expired_n;
    logic [15:0] hold;
    logic [15:0] next_hold;

    hsw_tick #(.DIVIDE(TICK_DIVIDE)) u_tick
    (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .tick_out  (tick)
    );

    // Pins come from the host's domain
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            host_kick_meta <= 1'b0;
            host_kick_sync <= 1'b0;
            host_kick_prev <= 1'b0;
            cfg_meta       <= 1'b0;
            cfg_sync       <= 1'b0;
        end
        else
        begin
            host_kick_meta <= host_kick_in;
            host_kick_sync <= host_kick_meta;
            host_kick_prev <= host_kick_sync;
            cfg_meta       <= app_config_done_event_in;
            cfg_sync       <= cfg_meta;
        end
    end

    assign kick_rise = host_kick_sync & ~host_kick_prev;

    // Interval sampled once after reset release; later changes wait for the next arst_n_in release
    always_comb
    begin
        next_latched  = 1'b1;
        next_interval = latched ? interval : boot_interval_in;
        if (!latched && boot_interval_in > 10'(INTERVAL_MAX_MS))
            next_interval = 10'(INTERVAL_MAX_MS);
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            latched  <= 1'b0;
            interval <= 10'h000;
        end
        else
        begin
            latched  <= next_latched;
            interval <= next_interval;
        end
    end

    // Internal watchdog runs from start-up, kicked by the protocol CPU
    hsw_counter u_cpu_wdt
    (
        .mclk_in     (mclk_in),
        .arst_n_in   (arst_n_in),
        .run_in      (device_reset_n_out),
        .reload_in   (cpu_kick_in),
        .tick_in     (tick),
        .interval_in (CPU_LIMIT_W),
        .expire_out  (cpu_expire)
    );

    assign host_run = (state == HSW_ARMED);

    hsw_counter u_host_wdt
    (
        .mclk_in     (mclk_in),
        .arst_n_in   (arst_n_in),
        .run_in      (host_run),
        .reload_in   (kick_rise),
        .tick_in     (tick),
        .interval_in (interval),
        .expire_out  (host_expire)
    );

    // Host supervision state; stays expired until device restart
    always_comb
    begin
        next_state = state;
        next_diag  = diag_out;
        case (state)
            HSW_IDLE:
            begin
                if (cfg_sync && latched && interval != INTERVAL_OFF)
                    next_state = HSW_ARMED;
            end
            HSW_ARMED:
            begin
                if (host_expire)
                begin
                    next_state                     = HSW_EXPIRED;
                    next_diag.alarm                = 1'b1;
                    next_diag.input_provider_state = 1'b0;
                end
            end
            HSW_EXPIRED:
                next_state = HSW_EXPIRED;
            default:
                next_state = HSW_IDLE;
        endcase
        // Device reset drops host supervision; diagnostics keep their state
        if (hold != 16'h0000)
            next_state = HSW_IDLE;
    end

    // Internal expiry pulls output low and holds a device reset for a fixed time
    always_comb
    begin
        next_wdt_expired_n = wdt_expired_n_out;
        next_hold          = hold;
        if (cpu_expire)
        begin
            next_wdt_expired_n = 1'b0;
            next_hold          = RESET_HOLD_W16;
        end
        else if (hold != 16'h0000)
            next_hold = hold - 16'h0001;
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state             <= HSW_IDLE;
            diag_out          <= '{alarm: 1'b0, input_provider_state: 1'b1};
            wdt_expired_n_out <= 1'b1;
            hold              <= 16'h0000;
        end
        else
        begin
            state             <= next_state;
            diag_out          <= next_diag;
            wdt_expired_n_out <= next_wdt_expired_n;
            hold              <= next_hold;
        end
    end

    // Reset request stays asserted while the hold counter runs
    assign device_reset_n_out = (hold == 16'h0000);
    assign host_active_out    = host_run;
endmodule

// ### hsw_pkg.sv
// Shared constants and carriers for the host supervision watchdog pair
package hsw_pkg;

    localparam int unsigned CLK_HZ             = 50_000_000;
    localparam int unsigned TICK_TIME_US       = 1000;
    localparam int unsigned TICK_CYCLES        = (CLK_HZ / 1_000_000) * TICK_TIME_US;
    localparam int unsigned INTERVAL_MIN_MS    = 1;
    localparam int unsigned INTERVAL_MAX_MS    = 512;
    localparam int unsigned INTERVAL_W         = 10;
    localparam logic [INTERVAL_W-1:0] INTERVAL_OFF = 10'h000;
    localparam int unsigned CPU_TIMEOUT_MS     = 100;
    localparam int unsigned RESET_HOLD_TIME_US = 10;
    localparam int unsigned RESET_HOLD_CYCLES  = (CLK_HZ / 1_000_000) * RESET_HOLD_TIME_US;
    localparam logic [15:0] RESET_HOLD_W16     = 16'(RESET_HOLD_CYCLES);

    typedef enum logic [1:0]
    {
        HSW_IDLE    = 2'b00,
        HSW_ARMED   = 2'b01,
        HSW_EXPIRED = 2'b10
    } hsw_state_e;

    typedef struct packed
    {
        logic alarm;
        logic input_provider_state;
    } hsw_diag_s;

endpackage

// ### hsw_tick.sv
// Millisecond enable pulse divider
`timescale 1ns/1ps
module hsw_tick
    import hsw_pkg::*;
#(
    parameter int unsigned DIVIDE = TICK_CYCLES
)
(
    input  wire logic mclk_in,
    input  wire logic arst_n_in,
    output logic      tick_out
);
    // Refused at elaboration: a divide below two gives no millisecond pulse; one holds the tick high every cycle
    if (DIVIDE < 2)
    begin : g_divide_check
        $error("DIVIDE must be at least 2");
    end

    logic [31:0] count;
    logic [31:0] next_count;
    logic        next_tick;

    always_comb
    begin
        next_tick  = (count == 32'(DIVIDE - 1));
        next_count = next_tick ? 32'h0000_0000 : count + 32'h0000_0001;
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            count    <= 32'h0000_0000;
            tick_out <= 1'b0;
        end
        else
        begin
            count    <= next_count;
            tick_out <= next_tick;
        end
    end
endmodule

// ### hsw_counter.sv
// One watchdog down-counter stepped by the millisecond enable
`timescale 1ns/1ps
module hsw_counter
    import hsw_pkg::*;
(
    input  wire logic                  mclk_in,
    input  wire logic                  arst_n_in,
    input  wire logic                  run_in,
    input  wire logic                  reload_in,
    input  wire logic                  tick_in,
    input  wire logic [INTERVAL_W-1:0] interval_in,
    output logic                       expire_out
);
    logic [INTERVAL_W-1:0] count;
    logic [INTERVAL_W-1:0] next_count;
    logic                  next_expire;

    always_comb
    begin
        next_count  = count;
        next_expire = 1'b0;
        if (!run_in || reload_in)
            next_count = interval_in;
        else if (tick_in)
        begin
            if (count <= 10'h001)
            begin
                next_expire = 1'b1;
                next_count  = interval_in;
            end
            else
                next_count = count - 10'h001;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            count      <= 10'h000;
            expire_out <= 1'b0;
        end
        else
        begin
            count      <= next_count;
            expire_out <= next_expire;
        end
    end
endmodule

// ### hsw_host_model.sv
// Host CPU model producing kick edges on the watchdog input
`timescale 1ns/1ps
module hsw_host_model
(
    input  wire logic       mclk_in,
    input  wire logic       arst_n_in,
    input  wire logic       enable_in,
    input  wire logic [7:0] half_period_in,
    output logic            host_kick_out
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic       next_kick;

    // Toggles every half period, so edges come well inside the interval
    always_comb
    begin
        next_count = count + 8'h01;
        next_kick  = host_kick_out;
        if (!enable_in)
        begin
            next_count = 8'h00;
        end
        else if (count >= half_period_in - 8'h01)
        begin
            next_count = 8'h00;
            next_kick  = !host_kick_out;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            count         <= 8'h00;
            host_kick_out <= 1'b0;
        end
        else
        begin
            count         <= next_count;
            host_kick_out <= next_kick;
        end
    end
endmodule

// ### hsw_top_checker.sv
// Concurrent checks on the watchdog pair ports
`timescale 1ns/1ps
module hsw_top_checker
    import hsw_pkg::*;
#(
    parameter int unsigned TICK_DIVIDE = TICK_CYCLES,
    parameter int unsigned CPU_LIMIT   = CPU_TIMEOUT_MS
)
(
    input wire logic                  mclk_in,
    input wire logic                  arst_n_in,
    input wire logic                  host_kick_in,
    input wire logic                  cpu_kick_in,
    input wire logic                  app_config_done_event_in,
    input wire logic [INTERVAL_W-1:0] boot_interval_in,
    input wire logic                  wdt_expired_n_out,
    input wire logic                  device_reset_n_out,
    input wire logic                  host_active_out,
    input wire hsw_diag_s             diag_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);

    AST_EXP_STICKY: assert property (!$rose(wdt_expired_n_out))
        else $error("expiry output released without reset");
    AST_EXP_CAUSE: assert property ($fell(wdt_expired_n_out) |-> !$past(cpu_kick_in, 2))
        else $error("expiry while internal cpu kicked");
    AST_RST_WITH_EXP: assert property ($fell(wdt_expired_n_out) |-> !device_reset_n_out)
        else $error("no device reset on internal expiry");
    AST_RST_HOLD: assert property ($fell(device_reset_n_out) |-> !device_reset_n_out[*8])
        else $error("device reset too short");
    AST_RST_IDLE: assert property (!device_reset_n_out |-> ##[0:2] !host_active_out)
        else $error("host supervision active during reset");
    AST_ARM_CAUSE: assert property ($rose(host_active_out) |-> $past(app_config_done_event_in, 2))
        else $error("armed without config done");
    AST_ALARM_STICKY: assert property (diag_out.alarm |=> diag_out.alarm)
        else $error("alarm dropped");
    AST_ALARM_BAD: assert property ($rose(diag_out.alarm) |-> !diag_out.input_provider_state)
        else $error("input data not marked bad");
    AST_ALARM_DISARM: assert property ($rose(diag_out.alarm) |-> ##[0:2] !host_active_out)
        else $error("supervision still active after alarm");

    COV_ARM: cover property ($rose(host_active_out));
    COV_ALARM: cover property ($rose(diag_out.alarm));
    COV_EXPIRY: cover property ($fell(wdt_expired_n_out));
endmodule

bind hsw_top hsw_top_checker #(.TICK_DIVIDE(TICK_DIVIDE), .CPU_LIMIT(CPU_LIMIT)) chk_i (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .host_kick_in(host_kick_in), .cpu_kick_in(cpu_kick_in),
    .app_config_done_event_in(app_config_done_event_in), .boot_interval_in(boot_interval_in),
    .wdt_expired_n_out(wdt_expired_n_out), .device_reset_n_out(device_reset_n_out),
    .host_active_out(host_active_out), .diag_out(diag_out));

// ### hsw_top_bench.sv
// Self-checking bench for the watchdog pair
`timescale 1ns/1ps
module hsw_top_bench
    import hsw_pkg::*;
;
    logic                  mclk     = 1'b0;
    logic                  arst_n   = 1'b0;
    logic                  cpu_kick = 1'b1;
    logic                  cfg_done = 1'b0;
    logic                  kick_en  = 1'b0;
    logic [INTERVAL_W-1:0] boot_iv  = 10'h004;
    logic                  host_kick;
    logic                  wdt_n;
    logic                  dev_rst_n;
    logic                  active;
    hsw_diag_s             diag;
    int                    errors = 0;
    int                    total_checks = 0;
    int                    cycles = 0;

    // Ten cycles per ms keeps every interval short
    hsw_top #(.TICK_DIVIDE(10), .CPU_LIMIT(4)) dut (.mclk_in(mclk), .arst_n_in(arst_n), .host_kick_in(host_kick),
        .cpu_kick_in(cpu_kick), .app_config_done_event_in(cfg_done), .boot_interval_in(boot_iv),
        .wdt_expired_n_out(wdt_n), .device_reset_n_out(dev_rst_n), .host_active_out(active), .diag_out(diag));
    hsw_host_model host (.mclk_in(mclk), .arst_n_in(arst_n), .enable_in(kick_en), .half_period_in(8'h08),
        .host_kick_out(host_kick));

    always #10 mclk = !mclk;

    task automatic wrap_up;
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            wrap_up();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic do_reset(input logic [INTERVAL_W-1:0] iv);
        arst_n   = 1'b0;
        cfg_done = 1'b0;
        kick_en  = 1'b0;
        boot_iv  = iv;
        cyc(6);
        arst_n = 1'b1;
    endtask

    task automatic t_kick;
        do_reset(10'h004);
        chk("wdt_n", 1'b1, wdt_n);
        chk("dev_rst_n", 1'b1, dev_rst_n);
        chk("ips", 1'b1, diag.input_provider_state);
        cyc(100);
        chk("active", 1'b0, active);
        chk("alarm", 1'b0, diag.alarm);
        cfg_done = 1'b1;
        kick_en  = 1'b1;
        cyc(20);
        chk("active", 1'b1, active);
        cyc(400);
        chk("alarm", 1'b0, diag.alarm);
        chk("wdt_n", 1'b1, wdt_n);
    endtask

    task automatic t_expire;
        kick_en = 1'b0;
        cyc(70);
        chk("alarm", 1'b1, diag.alarm);
        chk("ips", 1'b0, diag.input_provider_state);
        chk("active", 1'b0, active);
    endtask

    task automatic t_off;
        do_reset(10'h000);
        cfg_done = 1'b1;
        cyc(300);
        chk("active", 1'b0, active);
        chk("alarm", 1'b0, diag.alarm);
    endtask

    // Interval change after the latch edge must not matter
    task automatic t_late;
        do_reset(10'h002);
        cyc(2);
        boot_iv  = 10'h000;
        cfg_done = 1'b1;
        cyc(10);
        chk("active", 1'b1, active);
        chk("alarm", 1'b0, diag.alarm);
        cyc(30);
        chk("alarm", 1'b1, diag.alarm);
    endtask

    // Host drops its configuration on expiry and repeats it after restart
    task automatic t_cpu;
        do_reset(10'h004);
        cfg_done = 1'b1;
        kick_en  = 1'b1;
        cyc(20);
        chk("active", 1'b1, active);
        cpu_kick = 1'b0;
        cyc(60);
        chk("wdt_n", 1'b0, wdt_n);
        chk("dev_rst_n", 1'b0, dev_rst_n);
        chk("active", 1'b0, active);
        cpu_kick = 1'b1;
        cfg_done = 1'b0;
        cyc(500);
        chk("dev_rst_n", 1'b1, dev_rst_n);
        chk("wdt_n", 1'b0, wdt_n);
        chk("active", 1'b0, active);
        cfg_done = 1'b1;
        cyc(10);
        chk("active", 1'b1, active);
        cyc(100);
        chk("alarm", 1'b0, diag.alarm);
    endtask

    initial
    begin
        t_kick();
        t_expire();
        t_off();
        t_late();
        t_cpu();
        wrap_up();
    end
endmodule
